// ### iss_pkg.sv
// Shared constants and types for the two-wire slave block
package iss_pkg;
  localparam logic [3:0] ISS_LAST_BIT = 4'h7; // Bit index of the 8th fall
  localparam logic [3:0] ISS_ACK_BIT = 4'h8; // Bit index of the 9th fall
  localparam logic [4:0] ISS_TEN_HI_PAT = 5'h1e; // Leading pattern of a 10-bit high byte
  localparam logic [7:0] ISS_ADDR_RST = 8'h00; // Own address after reset
  localparam logic ISS_CKP_RST = 1'b1; // Clock released after reset
  localparam int unsigned ISS_EVT_N = 4; // Number of bus events
  localparam int unsigned ISS_EV_RISE = 0;
  localparam int unsigned ISS_EV_FALL = 1;
  localparam int unsigned ISS_EV_START = 2;
  localparam int unsigned ISS_EV_STOP = 3;
  typedef enum logic [2:0] {ISS_IDLE, ISS_ADDR, ISS_ADDR_LO, ISS_RX, ISS_TX} iss_phase_t;
endpackage : iss_pkg

// ### iss_evt_if.sv
// Event toggles carried from the line watcher to the system clock side
interface iss_evt_if;
  logic [3:0] tgl;
  logic sda_at_rise;
  modport watch (output tgl, output sda_at_rise);
  modport sync (input tgl, input sda_at_rise);
endinterface : iss_evt_if

// ### iss_line_watch.sv
// Bus line watcher on the link clock: edges, Start and Stop as toggles
module iss_line_watch
  import iss_pkg::*;
(
  input wire logic i_link_clk, // Link sampling clock
  input wire logic i_link_reset, // Synchronous reset, link domain
  input wire logic i_scl, // Bus clock line level
  input wire logic i_sda, // Bus data line level
  iss_evt_if.watch evt // Toggles to the system side
);
  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    logic [3:0] tgl;
    logic sda_r;
  } iss_watch_t;

  iss_watch_t s_q;
  iss_watch_t s_d;
  logic rise;
  logic fall;
  logic start;
  logic stop;

  // Edge and condition decode on the synchronised levels only
  always_comb begin
    s_d = s_q;
    rise = s_q.scl_s & ~s_q.scl_p;
    fall = ~s_q.scl_s & s_q.scl_p;
    start = s_q.scl_s & s_q.scl_p & s_q.sda_p & ~s_q.sda_s;
    stop = s_q.scl_s & s_q.scl_p & ~s_q.sda_p & s_q.sda_s;
    s_d.scl_m = i_scl;
    s_d.scl_s = s_q.scl_m;
    s_d.scl_p = s_q.scl_s;
    s_d.sda_m = i_sda;
    s_d.sda_s = s_q.sda_m;
    s_d.sda_p = s_q.sda_s;
    s_d.tgl = s_q.tgl ^ {stop, start, fall, rise};
    // Data held until the next rise, so it is stable across the crossing
    if (rise) begin
      s_d.sda_r = s_q.sda_s;
    end
  end

  // Idle bus reads high
  always_ff @(posedge i_link_clk) begin
    if (i_link_reset) begin
      s_q <= '{scl_m: 1'b1, scl_s: 1'b1, scl_p: 1'b1, sda_m: 1'b1, sda_s: 1'b1,
               sda_p: 1'b1, tgl: 4'h0, sda_r: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  assign evt.tgl = s_q.tgl;
  assign evt.sda_at_rise = s_q.sda_r;
endmodule : iss_line_watch

// ### iss_evt_sync.sv
// Toggle-to-pulse crossing of bus events into the system clock domain
module iss_evt_sync
  import iss_pkg::*;
(
  input wire logic i_clk, // System clock
  input wire logic i_reset, // Synchronous reset, active high
  iss_evt_if.sync evt, // Toggles from the watcher
  output logic [ISS_EVT_N-1:0] o_pulse, // One-cycle event pulses
  output logic o_sda // Data level sampled at the last rise
);
  typedef struct packed {
    logic [4:0] meta;
    logic [4:0] sync;
    logic [3:0] prev;
    logic [3:0] pulse;
  } iss_sync_t;

  iss_sync_t s_q;
  iss_sync_t s_d;

  // Two flops per bit; the pulse is one stage later than the data level
  always_comb begin
    s_d = s_q;
    s_d.meta = {evt.sda_at_rise, evt.tgl};
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync[3:0];
    s_d.pulse = s_q.sync[3:0] ^ s_q.prev;
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_pulse = s_q.pulse;
  assign o_sda = s_q.sync[4];
endmodule : iss_evt_sync

// ### iss_slave.sv
// Two-wire slave: read transfers, address hold, collision and 10-bit addressing
//
// Behaviour
// R1 - Matching read address: set direction, load buffer, acknowledge on ninth bit.
// R2 - After acknowledging a read, clear clock release and hold the clock low.
// R3 - Writing transmit data to the buffer also loads the shift register.
// R4 - Shift the transmit byte out one bit per falling clock edge.
// R5 - Latch master acknowledge on the ninth rising edge into acknowledge status.
// R6 - On master not-acknowledge, go idle until a new Start.
// R7 - On master not-acknowledge, do not stretch, but still raise the interrupt flag.
// R8 - On master acknowledge, stretch the clock until software releases it.
// R9 - Software loads the next byte, then sets clock release.
// R10 - Interrupt flag set per byte on the ninth fall; only software clears it.
// R11 - A collision while transmitting sets the collision flag when enabled.
// R12 - After a collision, go idle until addressed again.
// R13 - Start sets start-seen; interrupt only when start interrupts are enabled.
// R14 - Loading the buffer sets buffer full; reading it clears buffer full.
// R15 - Address hold: on the eighth fall, clear release, stretch, raise interrupt.
// R16 - Under hold, software picks the acknowledge value, then releases the clock.
// R17 - Software waits for the address acknowledge before loading transmit data.
// R18 - The master not-acknowledges the last byte it reads.
// R19 - 10-bit high byte write: set update flag, acknowledge, interrupt, hold clock.
// R20 - Writing the address register after the acknowledge releases the clock.
// R21 - Low byte mismatch: interrupt and update flag set, buffer full untouched.
// R22 - Software reloads the high address after a full 10-bit match.
// R23 - 10-bit data receive with stretching: clear release after each byte.
// R24 - Address or data hold in 10-bit mode behaves as in 7-bit mode.
// R25 - 10-bit high byte compares against 11110, address bits 2 and 1, zero.
// R26 - Acknowledge-time bit set at the eighth fall, only with hold enabled.
// R27 - Data hold clears clock release after the eighth fall of each data byte.
module iss_slave
  import iss_pkg::*;
(
  input wire logic i_clk, // System clock, 25 MHz
  input wire logic i_reset, // Synchronous reset, active high
  input wire logic i_link_clk, // Bus sampling clock
  input wire logic i_link_reset, // Reset for the sampling domain
  input wire logic i_scl, // Bus clock line level
  input wire logic i_sda, // Bus data line level
  output logic o_scl_o, // Bus clock drive value (always low)
  output logic o_scl_oe, // High while holding the bus clock low
  output logic o_sda_o, // Bus data drive value (always low)
  output logic o_sda_oe, // High while pulling the data line low
  input wire logic i_ten_bit_mode, // 10-bit addressing
  input wire logic i_address_hold_en, // Hold before address acknowledge
  input wire logic i_data_hold_en, // Hold before data acknowledge
  input wire logic i_clock_stretch_en, // Stretch after received bytes
  input wire logic i_slave_collision_detect_en, // Collision detection
  input wire logic i_start_irq_en, // Interrupt on Start
  input wire logic i_ack_value_select, // Acknowledge value under hold, 1 = NACK
  input wire logic i_addr_wr, // Write strobe for the address register
  input wire logic [7:0] i_addr_data, // Address register write data
  input wire logic i_buf_wr, // Write strobe for the buffer
  input wire logic [7:0] i_buf_data, // Buffer write data
  input wire logic i_buf_rd, // Buffer read strobe
  input wire logic i_ckp_set, // Sets the clock release bit
  input wire logic i_irq_clr, // Clears the interrupt flag
  input wire logic i_bcl_clr, // Clears the collision flag
  output logic [7:0] o_serial_buffer, // Buffer contents
  output logic [7:0] o_slave_address_reg, // Own address register
  output logic o_buffer_full_flag, // Buffer full
  output logic o_read_write, // Direction of the last address, 1 = read
  output logic o_clock_release_bit, // Clock release bit
  output logic o_ack_received_status, // Master acknowledge, 1 = NACK
  output logic o_ack_time_status, // Acknowledge time in progress
  output logic o_serial_irq_flag, // Serial interrupt flag
  output logic o_bus_collision_flag, // Bus collision flag
  output logic o_update_address_flag, // Address register update needed
  output logic o_start_seen // Start detected since last Stop
);
  typedef struct packed {
    iss_phase_t phase;
    logic [3:0] cnt;
    logic [7:0] rx_sr;
    logic [7:0] tx_sr;
    logic [7:0] buf_q;
    logic [7:0] addr;
    logic bf;
    logic rw;
    logic clock_release_bit;
    logic ack_stat;
    logic ack_tim;
    logic irq;
    logic bcl;
    logic ua;
    logic ua_hold;
    logic start_seen;
    logic scl_lo;
    logic sda_oe;
    logic hold_ack;
    logic ten_ok;
  } iss_state_t;

  iss_state_t s_q;
  iss_state_t s_d;
  iss_evt_if evt_if ();
  logic [ISS_EVT_N-1:0] ev;
  logic ev_sda;
  logic ev_rise;
  logic ev_fall;
  logic ev_start;
  logic ev_stop;
  logic addr_hit;
  logic lo_hit;
  logic quiet;

  iss_line_watch u_watch (
    .i_link_clk(i_link_clk),
    .i_link_reset(i_link_reset),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .evt(evt_if.watch)
  );

  iss_evt_sync u_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .evt(evt_if.sync),
    .o_pulse(ev),
    .o_sda(ev_sda)
  );

  // Event decode and address compare
  assign ev_rise = ev[ISS_EV_RISE];
  assign ev_fall = ev[ISS_EV_FALL];
  assign ev_start = ev[ISS_EV_START];
  assign ev_stop = ev[ISS_EV_STOP];
  assign quiet = !ev_start && !ev_stop;
  // R25 high byte pattern
  // A 10-bit read is only honoured after a full high and low write match
  assign addr_hit = i_ten_bit_mode
    ? (s_q.rx_sr[7:3] == ISS_TEN_HI_PAT && s_q.rx_sr[2:1] == s_q.addr[2:1] && (!s_q.rx_sr[0] || s_q.ten_ok))
    : (s_q.rx_sr[7:1] == s_q.addr[7:1]);
  assign lo_hit = (s_q.rx_sr == s_q.addr);

  // Next-state logic; software clears come first so hardware sets win
  always_comb begin
    s_d = s_q;
    if (i_irq_clr) begin
      s_d.irq = 1'b0;
    end
    if (i_bcl_clr) begin
      s_d.bcl = 1'b0;
    end
    // R14 read clears full
    if (i_buf_rd) begin
      s_d.bf = 1'b0;
    end
    if (i_ckp_set) begin
      s_d.clock_release_bit = 1'b1;
    end
    // R20 address write frees the clock
    if (i_addr_wr) begin
      s_d.addr = i_addr_data;
      s_d.ua = 1'b0;
      s_d.ua_hold = 1'b0;
    end
    // R3 R14 buffer write loads shifter
    if (i_buf_wr) begin
      s_d.buf_q = i_buf_data;
      s_d.bf = 1'b1;
      s_d.tx_sr = {i_buf_data[6:0], 1'b0};
      if (s_q.phase == ISS_TX) begin
        s_d.sda_oe = ~i_buf_data[7];
      end
    end
    // R16 software chosen acknowledge
    if (s_q.hold_ack) begin
      s_d.sda_oe = ~i_ack_value_select;
    end
    if (ev_rise && s_q.phase != ISS_IDLE) begin
      s_d.scl_lo = 1'b0;
      if (s_q.cnt < ISS_ACK_BIT) begin
        s_d.rx_sr = {s_q.rx_sr[6:0], ev_sda};
      end
      if (s_q.phase == ISS_TX) begin
        // R5 acknowledge on ninth rise
        if (s_q.cnt == ISS_ACK_BIT) begin
          s_d.ack_stat = ev_sda;
        // R11 R12 released line read low
        end else if (!s_q.sda_oe && !ev_sda && i_slave_collision_detect_en) begin
          s_d.bcl = 1'b1;
          s_d.phase = ISS_IDLE;
          s_d.sda_oe = 1'b0;
        end
      end
    end
    if (ev_fall && s_q.phase != ISS_IDLE) begin
      s_d.scl_lo = 1'b1;
      s_d.cnt = s_q.cnt + 4'h1;
      if (s_q.cnt == ISS_LAST_BIT) begin
        unique case (s_q.phase)
          ISS_ADDR, ISS_ADDR_LO: begin
            if (s_q.phase == ISS_ADDR ? addr_hit : lo_hit) begin
              // R1 address into buffer
              s_d.buf_q = s_q.rx_sr;
              s_d.bf = 1'b1;
              if (s_q.phase == ISS_ADDR) begin
                s_d.rw = s_q.rx_sr[0];
              end else begin
                s_d.ten_ok = 1'b1;
              end
              // R15 R24 R26 address hold
              if (i_address_hold_en) begin
                s_d.clock_release_bit = 1'b0;
                s_d.irq = 1'b1;
                s_d.ack_tim = 1'b1;
                s_d.hold_ack = 1'b1;
              end else begin
                s_d.sda_oe = 1'b1;
              end
            end else if (s_q.phase == ISS_ADDR) begin
              s_d.phase = ISS_IDLE;
            end
          end
          ISS_RX: begin
            s_d.buf_q = s_q.rx_sr;
            // Overflow: a byte left unread is not acknowledged
            if (!s_q.bf) begin
              s_d.bf = 1'b1;
              // R27 R24 R26 data hold
              if (i_data_hold_en) begin
                s_d.clock_release_bit = 1'b0;
                s_d.irq = 1'b1;
                s_d.ack_tim = 1'b1;
                s_d.hold_ack = 1'b1;
              end else begin
                s_d.sda_oe = 1'b1;
              end
            end
          end
          ISS_TX: begin
            // Byte sent: free the line for the master's answer
            s_d.sda_oe = 1'b0;
            s_d.bf = 1'b0;
          end
          default: begin
          end
        endcase
      end else if (s_q.cnt == ISS_ACK_BIT) begin
        s_d.cnt = 4'h0;
        s_d.sda_oe = 1'b0;
        s_d.hold_ack = 1'b0;
        s_d.ack_tim = 1'b0;
        unique case (s_q.phase)
          ISS_ADDR: begin
            if (!s_q.sda_oe) begin
              s_d.phase = ISS_IDLE;
            // R1 R2 read request stretches
            end else if (s_q.rw) begin
              s_d.irq = 1'b1;
              s_d.clock_release_bit = 1'b0;
              s_d.phase = ISS_TX;
            // R19 high byte write
            end else if (i_ten_bit_mode) begin
              s_d.irq = 1'b1;
              s_d.ua = 1'b1;
              s_d.ua_hold = 1'b1;
              s_d.ten_ok = 1'b0;
              s_d.phase = ISS_ADDR_LO;
            end else begin
              s_d.irq = 1'b1;
              s_d.clock_release_bit = ~i_clock_stretch_en & s_q.clock_release_bit;
              s_d.phase = ISS_RX;
            end
          end
          ISS_ADDR_LO: begin
            // R21 flag and hold even on mismatch
            s_d.irq = 1'b1;
            s_d.ua = 1'b1;
            s_d.ua_hold = 1'b1;
            s_d.phase = s_q.sda_oe ? ISS_RX : ISS_IDLE;
          end
          ISS_RX: begin
            // R23 stretch after each byte
            if (s_q.sda_oe) begin
              s_d.irq = 1'b1;
              s_d.clock_release_bit = ~i_clock_stretch_en & s_q.clock_release_bit;
            end else begin
              s_d.phase = ISS_IDLE;
            end
          end
          ISS_TX: begin
            // R10 R7 flag per byte
            s_d.irq = 1'b1;
            // R8 acknowledged: stretch
            if (!s_q.ack_stat) begin
              s_d.clock_release_bit = 1'b0;
            // R6 not acknowledged: idle
            end else begin
              s_d.phase = ISS_IDLE;
            end
          end
          default: begin
          end
        endcase
      end else if (s_q.phase == ISS_TX) begin
        // R4 next bit on each fall
        s_d.sda_oe = ~s_q.tx_sr[7];
        s_d.tx_sr = {s_q.tx_sr[6:0], 1'b0};
      end
    end
    // R13 Start and Restart
    if (ev_start) begin
      s_d.start_seen = 1'b1;
      s_d.irq = s_d.irq | i_start_irq_en;
      s_d.phase = ISS_ADDR;
      s_d.cnt = '1; // The Start's own clock fall wraps this to zero
      s_d.sda_oe = 1'b0;
      s_d.hold_ack = 1'b0;
      s_d.ack_tim = 1'b0;
    end
    if (ev_stop) begin
      s_d.start_seen = 1'b0;
      s_d.phase = ISS_IDLE;
      s_d.ten_ok = 1'b0;
      s_d.sda_oe = 1'b0;
      s_d.hold_ack = 1'b0;
      s_d.ack_tim = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      s_q <= '{phase: ISS_IDLE, cnt: 4'h0, rx_sr: 8'h00, tx_sr: 8'h00, buf_q: 8'h00,
               addr: ISS_ADDR_RST, clock_release_bit: ISS_CKP_RST, default: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // Clock is only held once it is already low, so no high time is cut short
  // R2 R8 R19 clock hold
  assign o_scl_oe = s_q.scl_lo & (~s_q.clock_release_bit | s_q.ua_hold);
  assign o_scl_o = 1'b0;
  assign o_sda_o = 1'b0;
  assign o_sda_oe = s_q.sda_oe;
  assign o_serial_buffer = s_q.buf_q;
  assign o_slave_address_reg = s_q.addr;
  assign o_buffer_full_flag = s_q.bf;
  assign o_read_write = s_q.rw;
  assign o_clock_release_bit = s_q.clock_release_bit;
  assign o_ack_received_status = s_q.ack_stat;
  assign o_ack_time_status = s_q.ack_tim;
  assign o_serial_irq_flag = s_q.irq;
  assign o_bus_collision_flag = s_q.bcl;
  assign o_update_address_flag = s_q.ua;
  assign o_start_seen = s_q.start_seen;

  // Checks on the sequencing above
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  a_read_addr_ack: assert property ( // R1
    ev_fall && quiet && s_q.phase == ISS_ADDR && s_q.cnt == ISS_LAST_BIT && addr_hit && s_q.rx_sr[0]
      && !i_address_hold_en |=> s_q.rw && s_q.sda_oe && s_q.bf)
    else $error("read address not acknowledged");
  a_read_stretch: assert property ( // R2
    ev_fall && quiet && s_q.phase == ISS_ADDR && s_q.cnt == ISS_ACK_BIT && s_q.sda_oe && s_q.rw
      |=> !s_q.clock_release_bit && s_q.phase == ISS_TX && o_scl_oe)
    else $error("clock not held after read acknowledge");
  a_tx_bit_out: assert property ( // R4
    ev_fall && quiet && s_q.phase == ISS_TX && s_q.cnt < ISS_LAST_BIT && !i_buf_wr
      |=> s_q.sda_oe == !$past(s_q.tx_sr[7]))
    else $error("wrong transmit bit");
  a_ack_latch: assert property ( // R5
    ev_rise && quiet && s_q.phase == ISS_TX && s_q.cnt == ISS_ACK_BIT |=> s_q.ack_stat == $past(ev_sda))
    else $error("master acknowledge not latched");
  a_nack_idle: assert property ( // R6 R7
    ev_fall && quiet && s_q.phase == ISS_TX && s_q.cnt == ISS_ACK_BIT && s_q.ack_stat
      |=> s_q.phase == ISS_IDLE && s_q.irq && s_q.clock_release_bit == $past(s_q.clock_release_bit))
    else $error("not-acknowledge handling wrong");
  a_ack_stretch: assert property ( // R8 R10
    ev_fall && quiet && s_q.phase == ISS_TX && s_q.cnt == ISS_ACK_BIT && !s_q.ack_stat
      |=> !s_q.clock_release_bit && s_q.irq && s_q.cnt == 4'h0)
    else $error("no stretch after acknowledged byte");
  a_collision: assert property ( // R11 R12
    ev_rise && quiet && s_q.phase == ISS_TX && s_q.cnt < ISS_ACK_BIT && !s_q.sda_oe && !ev_sda
      && i_slave_collision_detect_en |=> s_q.bcl && s_q.phase == ISS_IDLE && !o_sda_oe)
    else $error("collision not handled");
  a_start_flag: assert property ( // R13
    ev_start |=> s_q.start_seen && s_q.phase == ISS_ADDR && (s_q.irq || !$past(i_start_irq_en)))
    else $error("start not recorded");
  a_buf_full: assert property ( // R14
    i_buf_wr |=> s_q.bf ##1 (s_q.bf || $past(i_buf_rd) || $past(ev_fall)))
    else $error("buffer full not set by load");
  a_addr_hold: assert property ( // R15 R26
    ev_fall && quiet && s_q.phase == ISS_ADDR && s_q.cnt == ISS_LAST_BIT && addr_hit && i_address_hold_en
      |=> !s_q.clock_release_bit && s_q.irq && s_q.ack_tim ##1 !s_q.clock_release_bit || $past(i_ckp_set))
    else $error("address hold not applied");
  a_ua_hold: assert property ( // R19 R20
    s_q.ua_hold && s_q.scl_lo && !i_addr_wr |-> o_scl_oe ##1 (o_scl_oe || $past(i_addr_wr) || !s_q.scl_lo))
    else $error("clock not held for address update");

  c_tx_acked: cover property (ev_fall && s_q.phase == ISS_TX && s_q.cnt == ISS_ACK_BIT && !s_q.ack_stat);
  c_tx_nacked: cover property (ev_fall && s_q.phase == ISS_TX && s_q.cnt == ISS_ACK_BIT && s_q.ack_stat);
  c_ten_bit_rx: cover property (s_q.phase == ISS_ADDR_LO ##[1:1000] s_q.phase == ISS_RX);
  c_collision: cover property (!s_q.bcl ##1 s_q.bcl);
endmodule : iss_slave

// ### iss_master.sv
// Behavioural two-wire bus master that drives the slave under test
module iss_master (
  input wire logic i_scl, // Resolved clock line
  input wire logic i_sda, // Resolved data line
  output logic o_scl_low, // Pull clock line low
  output logic o_sda_low // Pull data line low
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam time T = 1200; // Half bit, well above the slave's edge latency
  // Lines released at power-up; the clock stands still between frames
  initial begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
  end
  // Release the clock, then wait while any slave stretches it
  task automatic clk_hi();
    o_scl_low = 1'b0;
    wait (i_scl === 1'b1);
    #T;
  endtask : clk_hi
  // Start: data falls while the clock is high
  task automatic start();
    #(T/4);
    o_sda_low = 1'b0;
    clk_hi();
    o_sda_low = 1'b1;
    #T;
    o_scl_low = 1'b1;
  endtask : start
  // Stop: data rises while the clock is high
  task automatic stop();
    #(T/4);
    o_sda_low = 1'b1;
    #T;
    clk_hi();
    o_sda_low = 1'b0;
    #T;
  endtask : stop
  // One bit: data changes only while the clock is low, sampled mid-high
  task automatic bit_io(input logic b, output logic s);
    #(T/4);
    o_sda_low = !b;
    #T;
    o_scl_low = 1'b0;
    wait (i_scl === 1'b1);
    #(T/2);
    s = i_sda;
    #(T/2);
    o_scl_low = 1'b1;
  endtask : bit_io
  // Byte MSB first, then the acknowledge bit; a 1 releases the data line
  task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] q, output logic r);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(a, r);
  endtask : byte_io
endmodule : iss_master

// ### i2c_slave_tx_and_10bit_rx_bench.sv
// Self-checking bench for the two-wire slave block
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; $display("BAD %s exp %h got %h", n, e, g); end end
module i2c_slave_tx_and_10bit_rx_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import iss_pkg::*;
  localparam int ADR = 0, WRB = 1, RDB = 2, REL = 3, IRC = 4, BCC = 5; // Strobe positions
  logic i_clk = 1'b0, i_reset = 1'b1, i_link_clk = 1'b0, i_link_reset = 1'b1;
  logic [5:0] stb = '0;
  logic [6:0] cfg = '0; // Mode, holds, stretch, collision, start irq, ack value
  logic [7:0] dat = '0, q;
  logic ack, m_scl, m_sda, hit;
  int fails = 0, comparisons = 0;
  logic o_scl_o, o_scl_oe, o_sda_o, o_sda_oe, o_buffer_full_flag, o_read_write, o_clock_release_bit;
  logic o_ack_received_status, o_ack_time_status, o_serial_irq_flag, o_bus_collision_flag;
  logic o_update_address_flag, o_start_seen;
  logic [7:0] o_serial_buffer, o_slave_address_reg;
  // Rows: address byte, two transmit bytes, expected address acknowledge
  logic [7:0] rows [3][4] = '{'{8'h53, 8'ha5, 8'h3c, 8'h00}, '{8'h55, 8'h00, 8'h00, 8'h01},
    '{8'h53, 8'h01, 8'hfe, 8'h00}};
  // Both lines have pull-ups, so a released line reads high
  wire logic scl = !(m_scl | o_scl_oe);
  wire logic sda = !(m_sda | o_sda_oe);
  iss_slave iss_slave_i (.i_clk, .i_reset, .i_link_clk, .i_link_reset, .i_scl(scl), .i_sda(sda), .o_scl_o,
    .o_scl_oe, .o_sda_o, .o_sda_oe, .i_ten_bit_mode(cfg[0]), .i_address_hold_en(cfg[1]),
    .i_data_hold_en(cfg[2]), .i_clock_stretch_en(cfg[3]), .i_slave_collision_detect_en(cfg[4]),
    .i_start_irq_en(cfg[5]), .i_ack_value_select(cfg[6]), .i_addr_wr(stb[ADR]), .i_addr_data(dat),
    .i_buf_wr(stb[WRB]), .i_buf_data(dat), .i_buf_rd(stb[RDB]), .i_ckp_set(stb[REL]), .i_irq_clr(stb[IRC]),
    .i_bcl_clr(stb[BCC]), .o_serial_buffer, .o_slave_address_reg, .o_buffer_full_flag, .o_read_write,
    .o_clock_release_bit, .o_ack_received_status, .o_ack_time_status, .o_serial_irq_flag,
    .o_bus_collision_flag, .o_update_address_flag, .o_start_seen);
  iss_master iss_master_i (.i_scl(scl), .i_sda(sda), .o_scl_low(m_scl), .o_sda_low(m_sda));
  // System clock, 40 ns period
  always #20 i_clk = ~i_clk;
  // Link clock, 32 ns period, offset so the phases stay unrelated
  initial begin
    #7;
    forever #16 i_link_clk = ~i_link_clk;
  end
  // One-cycle software strobe, then a short gap
  task automatic sw(input int k, input logic [7:0] d);
    @(posedge i_clk);
    stb <= 6'h01 << k;
    dat <= d;
    @(posedge i_clk);
    stb <= '0;
    repeat (3) @(posedge i_clk);
  endtask : sw
  task automatic set_cfg(input logic [6:0] v);
    @(posedge i_clk);
    cfg <= v;
  endtask : set_cfg
  // Covers the edge crossing latency with margin
  task automatic settle();
    repeat (25) @(posedge i_clk);
  endtask : settle
  task automatic end_of_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  // Main sequence
  initial begin
    repeat (6) @(posedge i_clk);
    i_reset <= 1'b0;
    i_link_reset <= 1'b0;
    settle();
    `CHK("reset release", ISS_CKP_RST, o_clock_release_bit);
    `CHK("reset address", ISS_ADDR_RST, o_slave_address_reg);
    `CHK("reset flags", 8'h00, {o_buffer_full_flag, o_serial_irq_flag, o_bus_collision_flag,
      o_update_address_flag, o_start_seen, o_ack_time_status, o_sda_oe, o_scl_oe});
    $display("test reset done");
    sw(ADR, 8'h52);
    foreach (rows[r]) begin
      iss_master_i.start();
      iss_master_i.byte_io(rows[r][0], 1'b1, q, ack);
      settle();
      hit = !rows[r][3][0];
      `CHK("address ack", rows[r][3][0], ack);
      `CHK("irq", hit, o_serial_irq_flag);
      if (hit) begin
        `CHK("direction", 1'b1, o_read_write);
        `CHK("buffer", rows[r][0], o_serial_buffer);
        `CHK("full", 1'b1, o_buffer_full_flag);
        `CHK("release", 1'b0, o_clock_release_bit);
        `CHK("held", 1'b1, o_scl_oe);
        sw(IRC, 8'h00);
        sw(RDB, 8'h00);
        `CHK("full read", 1'b0, o_buffer_full_flag);
        for (int k = 1; k < 3; k++) begin
          // load only after the address acknowledge, then release
          sw(WRB, rows[r][k]);
          `CHK("full load", 1'b1, o_buffer_full_flag);
          sw(REL, 8'h00);
          // last byte refused by the master
          iss_master_i.byte_io(8'hff, k == 2, q, ack);
          settle();
          `CHK("tx byte", rows[r][k], q);
          `CHK("ack status", k == 2, o_ack_received_status);
          `CHK("irq byte", 1'b1, o_serial_irq_flag);
          `CHK("stretch", k == 1, o_scl_oe);
          `CHK("release", k == 2, o_clock_release_bit);
          sw(IRC, 8'h00);
        end
      end
      iss_master_i.stop();
      settle();
      `CHK("stop", 1'b0, o_start_seen);
      `CHK("idle data", 1'b0, o_sda_oe);
    end
    $display("test rows done");
    set_cfg(7'h62);
    iss_master_i.start();
    settle();
    `CHK("start seen", 1'b1, o_start_seen);
    `CHK("start irq", 1'b1, o_serial_irq_flag);
    sw(IRC, 8'h00);
    fork
      iss_master_i.byte_io(8'h53, 1'b1, q, ack);
      begin
        repeat (600) @(posedge i_clk);
        `CHK("hold release", 1'b0, o_clock_release_bit);
        `CHK("hold irq", 1'b1, o_serial_irq_flag);
        `CHK("ack time", 1'b1, o_ack_time_status);
        `CHK("hold line", 1'b1, o_scl_oe);
        sw(REL, 8'h00);
      end
    join
    `CHK("chosen nack", 1'b1, ack);
    iss_master_i.stop();
    set_cfg(7'h01);
    sw(IRC, 8'h00);
    sw(RDB, 8'h00);
    $display("test hold done");
    sw(ADR, 8'h06);
    iss_master_i.start();
    iss_master_i.byte_io(8'hf6, 1'b1, q, ack);
    settle();
    `CHK("high ack", 1'b0, ack);
    `CHK("update", 1'b1, o_update_address_flag);
    `CHK("high held", 1'b1, o_scl_oe);
    `CHK("high irq", 1'b1, o_serial_irq_flag);
    sw(IRC, 8'h00);
    sw(RDB, 8'h00);
    // low address written after the acknowledge
    sw(ADR, 8'h34);
    `CHK("update clear", 1'b0, o_update_address_flag);
    `CHK("freed", 1'b0, o_scl_oe);
    iss_master_i.byte_io(8'h35, 1'b1, q, ack);
    settle();
    `CHK("low nack", 1'b1, ack);
    `CHK("low flags", 4'hb, {o_update_address_flag, o_buffer_full_flag, o_serial_irq_flag,
      o_clock_release_bit});
    sw(ADR, 8'h06);
    iss_master_i.start();
    iss_master_i.byte_io(8'hf6, 1'b1, q, ack);
    settle();
    sw(RDB, 8'h00);
    sw(ADR, 8'h34);
    iss_master_i.byte_io(8'h34, 1'b1, q, ack);
    settle();
    `CHK("low match", 10'h134, {ack, o_buffer_full_flag, o_serial_buffer});
    // high address back after a full match
    sw(ADR, 8'h06);
    iss_master_i.stop();
    $display("test ten bit done");
    set_cfg(7'h10);
    sw(ADR, 8'h52);
    sw(IRC, 8'h00);
    iss_master_i.start();
    iss_master_i.byte_io(8'h53, 1'b1, q, ack);
    settle();
    sw(RDB, 8'h00);
    sw(WRB, 8'hff);
    sw(REL, 8'h00);
    iss_master_i.byte_io(8'h00, 1'b1, q, ack);
    settle();
    `CHK("collision", 1'b1, o_bus_collision_flag);
    `CHK("gone idle", 2'b00, {o_sda_oe, o_scl_oe});
    iss_master_i.stop();
    sw(BCC, 8'h00);
    `CHK("collision clear", 1'b0, o_bus_collision_flag);
    $display("test collision done");
    end_of_test();
  end
  // Cut a hang short; the full run needs about 10000 cycles
  initial begin
    repeat (60000) @(posedge i_clk);
    fails++;
    end_of_test();
  end
endmodule : i2c_slave_tx_and_10bit_rx_bench
